// ===== hdl/kr_seq_ctrl_defines.svh
// Offsets, field positions, reset values and timing for the sequencer control register.
// Assumes word addressing on the management bus, one 32-bit register per word.
`ifndef KR_SEQ_CTRL_DEFINES_SVH
`define KR_SEQ_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define KR_REGION_LO          8'hB0
`define KR_REGION_HI          8'hFF
`define LINK_SEQ_CTRL_ADDR    8'hB0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEQ_RESTART_BIT       0
`define AN_TIMER_OFF_BIT      1
`define FAULT_TIMER_OFF_BIT   2
`define OVERRIDE_LSB          4
`define OVERRIDE_MSB          6
`define FEC_ADVERT_BIT        16
`define FEC_ERR_REPORT_BIT    17
`define FEC_REQUEST_BIT       18

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CTRL_RESET_VALUE      32'h0000_0000
`define RESTART_PULSE_CYCLES  1

`endif

// ===== hdl/kr_seq_ctrl_pkg.sv
// Types shared by the sequencer control register files.
// Assumes the defines header is compiled alongside.
package kr_seq_ctrl_pkg;

	// ----------------------------------------------------------------
	// Protocol override codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OVR_NONE   = 3'b000,
		OVR_GIGE   = 3'b001,
		OVR_RSV2   = 3'b010,
		OVR_RSV3   = 3'b011,
		OVR_10G_R  = 3'b100,
		OVR_10G_KR = 3'b101,
		OVR_RSV6   = 3'b110,
		OVR_RSV7   = 3'b111
	} protocol_override_t;

	typedef enum logic [1:0] {
		MODE_AUTO  = 2'b00,
		MODE_GIGE  = 2'b01,
		MODE_10G_R = 2'b10,
		MODE_10G_KR = 2'b11
	} seq_mode_t;

endpackage

// ===== hdl/kr_override_decode.sv
// Decoder from the stored protocol override code to a forced sequencer mode.
// Assumes the code is stable while it is sampled on a restart.
`timescale 1ns/1ps

module kr_override_decode (
	input  wire logic [2:0]                  code,
	output      kr_seq_ctrl_pkg::seq_mode_t  mode,
	output      logic                        forced,
	output      logic                        reserved_code
);

	// [RULE6] Override code decode
	always_comb begin
		mode          = kr_seq_ctrl_pkg::MODE_AUTO;
		forced        = 1'b0;
		reserved_code = 1'b0;
		case (kr_seq_ctrl_pkg::protocol_override_t'(code))
			kr_seq_ctrl_pkg::OVR_NONE: begin
				mode = kr_seq_ctrl_pkg::MODE_AUTO;
			end
			kr_seq_ctrl_pkg::OVR_GIGE: begin
				mode   = kr_seq_ctrl_pkg::MODE_GIGE;
				forced = 1'b1;
			end
			kr_seq_ctrl_pkg::OVR_10G_R: begin
				mode   = kr_seq_ctrl_pkg::MODE_10G_R;
				forced = 1'b1;
			end
			kr_seq_ctrl_pkg::OVR_10G_KR: begin
				mode   = kr_seq_ctrl_pkg::MODE_10G_KR;
				forced = 1'b1;
			end
			// [RULE7] Reserved codes fall back
			default: begin
				mode          = kr_seq_ctrl_pkg::MODE_AUTO;
				reserved_code = 1'b1;
			end
		endcase
	end

endmodule

// ===== hdl/kr_sequencer_control_regs.sv
// Sequencer control register of the backplane link, on the management bus.
// Assumes a word-addressed management slave with one-cycle read latency.
//
// Overview of operation
// [RULE1] Writing one to bit 0 pulses restart: sequencer reset, PCS reconfig, AN/LT restart.
// [RULE2] Restart bit clears itself; software never writes zero to it.
// [RULE3] Bit 1 set stops the auto-negotiation timer; clear keeps it running.
// [RULE4] Software rescues stalled negotiation when its timer is disabled.
// [RULE5] Bit 2 set stops the link-fault timer; clear enables it.
// [RULE6] Override field 6:4: 000 none, 001 gigabit, 100 10GBASE-R, 101 10GBASE-KR.
// [RULE7] Codes 010, 011, 110, 111 are reserved; software avoids them.
// [RULE8] New override takes effect only at the next restart write.
// [RULE9] Bit 16 advertises FEC support.
// [RULE10] FEC advertisement resets to one when the build option is on.
// [RULE11] Bit 17 passes FEC decode errors to the 10G PCS.
// [RULE12] Fields reset to zero unless stated otherwise.
// [RULE13] Software avoids writing reserved or undefined addresses.
// [RULE14] Software updates registers by read-modify-write.
// [RULE15] All registers sit in one address space on the management bus.
// [RULE16] Backplane PHY registers occupy word offsets 0xB0 through 0xFF.
// [RULE17] Four-lane build applies training and FEC controls to lane 0.
// [RULE18] Software restarts the sequencer after changing the FEC request bit.
// [RULE19] Restart bit reads zero one clock after its write.
`timescale 1ns/1ps
`include "kr_seq_ctrl_defines.svh"

module kr_sequencer_control_regs #(
	parameter bit FEC_ADVERT_AT_RESET = 1'b0,
	parameter int NUM_LANES           = 4
) (
	input  wire logic                         core_clk,
	input  wire logic                         rstn,
	input  wire logic [7:0]                   mgmt_addr,
	input  wire logic                         mgmt_write,
	input  wire logic [31:0]                  mgmt_writedata,
	input  wire logic                         mgmt_read,
	output      logic [31:0]                  mgmt_readdata,
	output      logic                         mgmt_readdata_valid,
	output      logic                         sequencer_restart,
	output      logic                         autoneg_timer_off,
	output      logic                         fault_timer_off,
	output      kr_seq_ctrl_pkg::seq_mode_t   active_mode,
	output      logic                         mode_forced,
	output      logic [NUM_LANES-1:0]         fec_capability_advert,
	output      logic [NUM_LANES-1:0]         fec_error_report_en,
	output      logic [NUM_LANES-1:0]         fec_request_advert
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic hit_ctrl(input logic [7:0] a);
		return a == `LINK_SEQ_CTRL_ADDR;
	endfunction

	logic        wr_ctrl;
	logic        rd_ctrl;
	// [RULE15] Single shared address space
	// [RULE16] Decodes only offset 0xB0 of the backplane region
	assign wr_ctrl = mgmt_write && hit_ctrl(mgmt_addr);
	assign rd_ctrl = mgmt_read && hit_ctrl(mgmt_addr);

	// ----------------------------------------------------------------
	// Stored fields
	// ----------------------------------------------------------------
	logic        restart_r;
	logic        an_off_r;
	logic        lf_off_r;
	logic [2:0]  override_r;
	logic [2:0]  override_live_r;
	logic        fec_advert_r;
	logic        fec_err_r;
	logic        fec_req_r;

	// [RULE1] Restart pulse on write of one
	// [RULE2] Self clears next cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= wr_ctrl && mgmt_writedata[`SEQ_RESTART_BIT];
		end
	end

	// [RULE3] Timer disables held as written
	// [RULE5] Link-fault timer disable
	// [RULE12] Zero reset defaults
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			an_off_r   <= 1'b0;
			lf_off_r   <= 1'b0;
			override_r <= 3'h0;
			fec_err_r  <= 1'b0;
			fec_req_r  <= 1'b0;
		end else if (wr_ctrl) begin
			an_off_r   <= mgmt_writedata[`AN_TIMER_OFF_BIT];
			lf_off_r   <= mgmt_writedata[`FAULT_TIMER_OFF_BIT];
			override_r <= mgmt_writedata[`OVERRIDE_MSB:`OVERRIDE_LSB];
			fec_err_r  <= mgmt_writedata[`FEC_ERR_REPORT_BIT];
			fec_req_r  <= mgmt_writedata[`FEC_REQUEST_BIT];
		end
	end

	// [RULE10] Build option picks advert reset
	// The option is a build constant, so the async reset branch may load it directly.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fec_advert_r <= FEC_ADVERT_AT_RESET;
		end else if (wr_ctrl) begin
			fec_advert_r <= mgmt_writedata[`FEC_ADVERT_BIT];
		end
	end

	// [RULE8] Override applied only on restart
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			override_live_r <= 3'h0;
		end else if (restart_r) begin
			override_live_r <= override_r;
		end
	end

	// Decode reads the applied copy, so a rewrite alone never moves the mode
	kr_override_decode u_decode (
		.code          (override_live_r),
		.mode          (active_mode),
		.forced        (mode_forced),
		.reserved_code ()
	);

	// ----------------------------------------------------------------
	// Outputs to the sequencer and FEC lanes
	// ----------------------------------------------------------------
	assign sequencer_restart = restart_r;
	assign autoneg_timer_off = an_off_r;
	assign fault_timer_off   = lf_off_r;

	// [RULE17] Per-lane FEC controls, lane 0 only
	genvar ln;
	generate
		for (ln = 0; ln < NUM_LANES; ln++) begin : g_lane
			if (ln == 0) begin : g_l0
				// [RULE9] FEC advertisement drive
				assign fec_capability_advert[ln] = fec_advert_r;
				// [RULE11] Error report enable drive
				assign fec_error_report_en[ln]   = fec_err_r;
				assign fec_request_advert[ln]    = fec_req_r;
			end else begin : g_ln
				assign fec_capability_advert[ln] = 1'b0;
				assign fec_error_report_en[ln]   = 1'b0;
				assign fec_request_advert[ln]    = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [31:0] ctrl_view;
	always_comb begin
		ctrl_view = 32'h0000_0000;
		// [RULE19] Restart reads back as zero
		ctrl_view[`SEQ_RESTART_BIT]                 = 1'b0;
		ctrl_view[`AN_TIMER_OFF_BIT]                = an_off_r;
		ctrl_view[`FAULT_TIMER_OFF_BIT]             = lf_off_r;
		ctrl_view[`OVERRIDE_MSB:`OVERRIDE_LSB]      = override_r;
		ctrl_view[`FEC_ADVERT_BIT]                  = fec_advert_r;
		ctrl_view[`FEC_ERR_REPORT_BIT]              = fec_err_r;
		ctrl_view[`FEC_REQUEST_BIT]                 = fec_req_r;
	end

	// Unmapped addresses read zero, so a stray probe never sees stale data.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mgmt_readdata       <= 32'h0000_0000;
			mgmt_readdata_valid <= 1'b0;
		end else begin
			mgmt_readdata_valid <= mgmt_read;
			mgmt_readdata       <= rd_ctrl ? ctrl_view : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	chk_restart_pulse: assert property (wr_ctrl && mgmt_writedata[0] |=> sequencer_restart) // [RULE1]
		else $error("restart write gave no pulse");
	chk_restart_clear: assert property (sequencer_restart && !(wr_ctrl && mgmt_writedata[0]) // [RULE2]
			|=> !sequencer_restart)
		else $error("restart did not self clear");
	chk_an_timer_bit: assert property (wr_ctrl |=> autoneg_timer_off == $past(mgmt_writedata[1])) // [RULE3]
		else $error("autoneg timer control wrong");
	chk_lf_timer_bit: assert property (wr_ctrl |=> fault_timer_off == $past(mgmt_writedata[2])) // [RULE5]
		else $error("fault timer control wrong");
	chk_override_hold: assert property (!sequencer_restart |=> $stable(active_mode)) // [RULE8]
		else $error("override applied without restart");
	// Mode checks look one cycle past the pulse, where the applied copy lands
	chk_override_kr: assert property (sequencer_restart && override_r == 3'b101 // [RULE6]
			|=> active_mode == kr_seq_ctrl_pkg::MODE_10G_KR && mode_forced)
		else $error("KR override not decoded");
	chk_override_gige: assert property (sequencer_restart && override_r == 3'b001 // [RULE6]
			|=> active_mode == kr_seq_ctrl_pkg::MODE_GIGE && mode_forced)
		else $error("gigabit override not decoded");
	chk_override_rsv: assert property (sequencer_restart && override_r == 3'b010 |=> !mode_forced) // [RULE7]
		else $error("reserved override forced a mode");
	chk_fec_advert: assert property (wr_ctrl |=> fec_capability_advert[0] == $past(mgmt_writedata[16])) // [RULE9]
		else $error("FEC advert not updated");
	chk_fec_err: assert property (wr_ctrl |=> fec_error_report_en[0] == $past(mgmt_writedata[17])) // [RULE11]
		else $error("FEC error report not updated");
	chk_fec_request: assert property (wr_ctrl |=> fec_request_advert[0] == $past(mgmt_writedata[18])) // [RULE17]
		else $error("FEC request not updated");
	chk_restart_read: assert property (mgmt_readdata_valid |-> mgmt_readdata[0] == 1'b0) // [RULE19]
		else $error("restart bit read as one");
	chk_read_valid: assert property (mgmt_read |=> mgmt_readdata_valid) // [RULE15]
		else $error("read gave no valid");
	chk_unmapped_zero: assert property (mgmt_read && !hit_ctrl(mgmt_addr) |=> mgmt_readdata == 32'h0000_0000) // [RULE16]
		else $error("unmapped read not zero");

	cov_restart: cover property (wr_ctrl && mgmt_writedata[0] ##1 sequencer_restart ##1 !sequencer_restart);
	cov_force_gige: cover property (active_mode == kr_seq_ctrl_pkg::MODE_GIGE);
	cov_read_ctrl: cover property (rd_ctrl ##1 mgmt_readdata_valid);
	cov_force_kr: cover property (active_mode == kr_seq_ctrl_pkg::MODE_10G_KR);
	cov_unmapped_read: cover property (mgmt_read && !hit_ctrl(mgmt_addr));

endmodule

// ===== verification/kr_mgmt_host.sv
// Host model driving the management bus of the sequencer control register.
// Assumes the bench clock; every change lands 1 ns after a rising edge.
`timescale 1ns/1ps

module kr_mgmt_host (
	input  wire logic        core_clk,
	input  wire logic [31:0] mgmt_readdata,
	input  wire logic        mgmt_readdata_valid,
	output      logic [7:0]  mgmt_addr,
	output      logic        mgmt_write,
	output      logic [31:0] mgmt_writedata,
	output      logic        mgmt_read
);
	initial begin
		mgmt_addr = 8'h00;
		mgmt_write = 1'b0;
		mgmt_writedata = 32'h0000_0000;
		mgmt_read = 1'b0;
	end

	// Released lines are scrambled so the design cannot lean on stale values
	task automatic release_bus();
		mgmt_write = 1'b0;
		mgmt_read = 1'b0;
		mgmt_addr = ~mgmt_addr;
		mgmt_writedata = ~mgmt_writedata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk) #1;
		mgmt_addr = a;
		mgmt_writedata = d;
		mgmt_write = 1'b1;
		@(posedge core_clk) #1;
		release_bus();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
		int i;
		@(posedge core_clk) #1;
		mgmt_addr = a;
		mgmt_read = 1'b1;
		@(posedge core_clk) #1;
		release_bus();
		ok = 1'b0;
		d = 32'h0000_0000;
		for (i = 0; i < 4 && ok !== 1'b1; i++) begin
			if (mgmt_readdata_valid === 1'b1) begin
				ok = 1'b1;
				d = mgmt_readdata;
			end else begin
				@(posedge core_clk) #1;
			end
		end
	endtask

	// Read-modify-write keeps the bits outside the mask
	task automatic rmw(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] d;
		logic        ok;
		rd(a, d, ok);
		wr(a, (d & ~m) | (v & m));
	endtask
endmodule

// ===== verification/kr_sequencer_control_regs_tb.sv
// Self-checking bench for the sequencer control register.
// Assumes the host model and a 200 MHz clock; FEC advert build option on.
`timescale 1ns/1ps

module kr_sequencer_control_regs_tb;
	logic                       core_clk;
	logic                       rstn;
	logic [7:0]                 mgmt_addr;
	logic                       mgmt_write;
	logic [31:0]                mgmt_writedata;
	logic                       mgmt_read;
	logic [31:0]                mgmt_readdata;
	logic                       mgmt_readdata_valid;
	logic                       sequencer_restart;
	logic                       autoneg_timer_off;
	logic                       fault_timer_off;
	kr_seq_ctrl_pkg::seq_mode_t active_mode;
	logic                       mode_forced;
	logic [3:0]                 fec_capability_advert;
	logic [3:0]                 fec_error_report_en;
	logic [3:0]                 fec_request_advert;
	logic [31:0]                rdata;
	logic                       ok;
	int                         n_fail;
	int                         n_compared;
	int                         n_pulse;
	int                         code;

	kr_sequencer_control_regs #(.FEC_ADVERT_AT_RESET(1'b1), .NUM_LANES(4)) DUT (.core_clk(core_clk), .rstn(rstn),
		.mgmt_addr(mgmt_addr), .mgmt_write(mgmt_write), .mgmt_writedata(mgmt_writedata), .mgmt_read(mgmt_read),
		.mgmt_readdata(mgmt_readdata), .mgmt_readdata_valid(mgmt_readdata_valid),
		.sequencer_restart(sequencer_restart), .autoneg_timer_off(autoneg_timer_off),
		.fault_timer_off(fault_timer_off), .active_mode(active_mode), .mode_forced(mode_forced),
		.fec_capability_advert(fec_capability_advert), .fec_error_report_en(fec_error_report_en),
		.fec_request_advert(fec_request_advert));

	kr_mgmt_host HOST (.core_clk(core_clk), .mgmt_readdata(mgmt_readdata),
		.mgmt_readdata_valid(mgmt_readdata_valid), .mgmt_addr(mgmt_addr), .mgmt_write(mgmt_write),
		.mgmt_writedata(mgmt_writedata), .mgmt_read(mgmt_read));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (sequencer_restart === 1'b1) n_pulse <= n_pulse + 1;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask

	task automatic finish_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		HOST.rd(a, rdata, ok);
		chk("read_valid", 32'h1, {31'h0, ok});
		if (ok !== 1'b1) begin
			finish_test();
		end else begin
			chk(name, exp, rdata);
		end
	endtask

	// Packs {forced, mode}; reserved codes fall back to no override
	function automatic logic [2:0] exp_mode(input logic [2:0] c);
		case (c)
			3'h1: return {1'b1, kr_seq_ctrl_pkg::MODE_GIGE};
			3'h4: return {1'b1, kr_seq_ctrl_pkg::MODE_10G_R};
			3'h5: return {1'b1, kr_seq_ctrl_pkg::MODE_10G_KR};
			default: return {1'b0, kr_seq_ctrl_pkg::MODE_AUTO};
		endcase
	endfunction

	function automatic logic [31:0] e(input logic [2:0] f, input logic [2:0] fm, input logic [1:0] t);
		return {15'h0, 3'h0, f[2], 3'h0, f[1], 3'h0, f[0], fm, t};
	endfunction

	function automatic logic [31:0] outs();
		return {15'h0, fec_request_advert, fec_error_report_en, fec_capability_advert, mode_forced,
			active_mode, fault_timer_off, autoneg_timer_off};
	endfunction

	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		finish_test();
	end

	initial begin
		n_fail = 0;
		n_compared = 0;
		n_pulse = 0;
		rstn = 1'b0;
		repeat (3) @(posedge core_clk);
		#1 rstn = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk("outputs", e(3'h1, exp_mode(3'h0), 2'h0), outs());
		rd_chk("ctrl", 8'hB0, 32'h0001_0000);
		// Timers and a new override without restart: mode must not move
		HOST.rmw(8'hB0, 32'h0000_0076, 32'h0000_0046);
		chk("outputs", e(3'h1, exp_mode(3'h0), 2'h3), outs());
		chk("restarts", 32'h0, n_pulse);
		rd_chk("ctrl", 8'hB0, 32'h0001_0046);
		// Software takes the stalled negotiation back by re-enabling both timers
		HOST.rmw(8'hB0, 32'h0000_0006, 32'h0000_0000);
		chk("outputs", e(3'h1, exp_mode(3'h0), 2'h0), outs());
		// Every override code in turn, each with its own restart write
		for (code = 0; code < 8; code++) begin
			HOST.wr(8'hB0, {25'h0, code[2:0], 4'h1});
			chk("restart", 32'h1, {31'h0, sequencer_restart});
			@(posedge core_clk) #1;
			chk("restart", 32'h0, {31'h0, sequencer_restart});
			chk("mode", {29'h0, exp_mode(code[2:0])}, {29'h0, mode_forced, active_mode});
			rd_chk("ctrl", 8'hB0, {25'h0, code[2:0], 4'h0});
		end
		chk("restarts", 32'h8, n_pulse);
		HOST.wr(8'hB0, 32'hFFFF_FFFE);
		rd_chk("ctrl", 8'hB0, 32'h0007_0076);
		chk("outputs", e(3'h7, exp_mode(3'h7), 2'h3), outs());
		HOST.rmw(8'hB0, 32'h0000_0070, 32'h0000_0050);
		chk("mode", {29'h0, exp_mode(3'h7)}, {29'h0, mode_forced, active_mode});
		HOST.rmw(8'hB0, 32'h0000_0001, 32'h0000_0001);
		@(posedge core_clk) #1;
		chk("mode", {29'h0, exp_mode(3'h5)}, {29'h0, mode_forced, active_mode});
		// Unmapped places are refused silently
		HOST.wr(8'hB1, 32'hFFFF_FFFF);
		HOST.wr(8'hFF, 32'h0000_0000);
		rd_chk("ctrl", 8'hB0, 32'h0007_0056);
		rd_chk("unmapped", 8'hB1, 32'h0000_0000);
		rd_chk("unmapped", 8'h10, 32'h0000_0000);
		chk("restarts", 32'h9, n_pulse);
		// Reset in mid-run: the advert holds its build-time value while reset is low
		@(posedge core_clk) #1 rstn = 1'b0;
		@(posedge core_clk) #1;
		chk("outputs", e(3'h1, exp_mode(3'h0), 2'h0), outs());
		rstn = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk("outputs", e(3'h1, exp_mode(3'h0), 2'h0), outs());
		rd_chk("ctrl", 8'hB0, 32'h0001_0000);
		finish_test();
	end
endmodule
